/* common/olcg_pkg.sv */
/*
  Constants, types and lock-map decoding for the lock map and command
  gating block. Assumes a 20 MHz system clock and a 32-bit command
  frame from the serial link: opcode, 16-bit address, data byte.
*/
package olcg_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ          = 20;
  localparam int POWER_UP_US      = 300;
  // Longest time, rounded down
  localparam int POWER_UP_CYC     = POWER_UP_US * CLK_MHZ;
  localparam int ACCEL_SETTLE_US  = 5;
  // Least time, rounded up
  localparam int ACCEL_SETTLE_CYC = ACCEL_SETTLE_US * CLK_MHZ;
  localparam int SETTLE_W         = 7;
  localparam int PU_W             = 13;

  // ==========================================================
  // Command frame layout
  localparam int FRAME_W   = 32;
  localparam int OPC_LSB   = 24;
  localparam int ADDR_LSB  = 8;
  localparam int CNT_W     = 6;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_OTP_PROGRAM   = 8'h42;
  localparam logic [7:0] OP_DEEP_PD       = 8'hB9;
  localparam logic [7:0] OP_RELEASE_PD    = 8'hAB;

  // ==========================================================
  // Lock bytes and region addresses
  localparam logic [15:0] LOCK_ESN_ADDR  = 16'h0100;
  localparam logic [15:0] LOCK_OTP_LO    = 16'h0214;
  localparam logic [15:0] LOCK_OTP_HI    = 16'h0215;
  localparam logic [15:0] SER1_FIRST     = 16'h0102;
  localparam logic [15:0] SER1_LAST      = 16'h0109;
  localparam logic [15:0] SER2_FIRST     = 16'h010A;
  localparam logic [15:0] SER2_LAST      = 16'h0111;
  localparam logic [15:0] OTP_HI_FIRST   = 16'h0216;
  localparam logic [15:0] OTP_HI_LAST    = 16'h02FF;
  localparam int          OTP_REGION_SH  = 4;
  localparam int          SER1_LOCK_BIT  = 0;
  localparam int          SER2_LOCK_BIT  = 1;
  localparam logic [7:0]  ESN_PROG_MASK  = 8'h03;
  localparam logic [7:0]  OTP_LO_MASK    = 8'hFF;
  localparam logic [7:0]  OTP_HI_MASK    = 8'h7F;

  // ==========================================================
  // Reset and delivery values
  localparam logic [7:0] LOCK_RESET    = 8'hFF;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] CONFIG_RESET  = 8'h00;
  localparam logic [7:0] ERASED_BYTE   = 8'hFF;
  localparam int         CFG_QUAD_BIT  = 1;
  localparam int         STS_WREN_BIT  = 1;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_STATE  = 5'h04;
  localparam logic [4:0] REG_LOCKS  = 5'h08;
  localparam logic [4:0] REG_COUNTS = 5'h0C;
  localparam logic [4:0] REG_FLASH  = 5'h10;
  localparam int ST_READY    = 0;
  localparam int ST_WREN     = 1;
  localparam int ST_DEEP     = 2;
  localparam int ST_ACCEL    = 3;
  localparam int ST_SETTLING = 4;
  localparam int ST_BLOCKED  = 5;
  localparam int ST_VCC_OK   = 6;

  // ==========================================================
  // Power state
  typedef enum logic [1:0] {
    PWR_WAIT    = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_DEEP    = 2'b10
  } olcg_pwr_e;

  // Whether an address falls in a region whose lock bit is zero
  function automatic logic region_locked(
    input logic [15:0] addr,
    input logic [7:0]  lk_esn,
    input logic [7:0]  lk_lo,
    input logic [7:0]  lk_hi
  );
    logic [15:0] ofs;
    logic [14:0] vec;
    ofs = 16'h0000;
    vec = {lk_hi[6:0], lk_lo};
    region_locked = 1'b0;
    if (addr >= SER1_FIRST && addr <= SER1_LAST) begin
      region_locked = ~lk_esn[SER1_LOCK_BIT];
    end else if (addr >= SER2_FIRST && addr <= SER2_LAST) begin
      region_locked = ~lk_esn[SER2_LOCK_BIT];
    end else if (addr >= OTP_HI_FIRST && addr <= OTP_HI_LAST) begin
      ofs = (addr - OTP_HI_FIRST) >> OTP_REGION_SH;
      region_locked = ~vec[ofs[3:0]];
    end
  endfunction

endpackage

/* rtl/olcg_link_rx.sv */
/*
  Serial link receiver on the host's serial clock. Shifts a 32-bit
  frame MSB first while select is low, then holds it and flips a toggle.
  Assumes the host keeps each frame stable until the next one ends and
  that the serial clock may stop between frames.
*/
`timescale 1ns/100ps
module olcg_link_rx (
  // Link
  input  wire logic                         spi_sck_i,
  input  wire logic                         spi_cs_n_i,
  input  wire logic                         spi_mosi_i,
  // Reset
  input  wire logic                         rst_n_i,
  // Captured frame
  output logic [olcg_pkg::FRAME_W-1:0]      frame_o,
  output logic                              frame_tgl_o
);

  logic [olcg_pkg::FRAME_W-1:0] shift_q;
  logic [olcg_pkg::CNT_W-1:0]   bit_cnt_q;
  logic                         frame_rst_n;
  logic                         last_bit;

  // Select high ends a frame and clears the partial shift
  assign frame_rst_n = rst_n_i & ~spi_cs_n_i;
  assign last_bit    = (bit_cnt_q == olcg_pkg::CNT_W'(olcg_pkg::FRAME_W-1));

  // ==========================================================
  // Shift register
  always_ff @(posedge spi_sck_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_q   <= '0;
      bit_cnt_q <= '0;
    end else begin
      shift_q   <= {shift_q[olcg_pkg::FRAME_W-2:0], spi_mosi_i};
      bit_cnt_q <= last_bit ? '0 : bit_cnt_q + 1'b1;
    end
  end

  // Hold completed frame and flag it by a toggle
  always_ff @(posedge spi_sck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_o     <= '0;
      frame_tgl_o <= 1'b0;
    end else if (!spi_cs_n_i && last_bit) begin
      frame_o     <= {shift_q[olcg_pkg::FRAME_W-2:0], spi_mosi_i};
      frame_tgl_o <= ~frame_tgl_o;
    end
  end

endmodule // olcg_link_rx

/* rtl/olcg_top.sv */
/*
  Lock map and command gating of a serial flash: lock bytes, write
  enable, power-up hold, undervoltage and acceleration-pin gating.
  Assumes supply-good and high-voltage pin levels arrive asynchronously
  and a software master on Avalon-MM with waitrequest.
*/
// The register addresses and register access over Avalon-MM were left to the implementer.
// Function
// - Lock bits only go one to zero; a locked region stays locked.
// - Bit 0 of byte 0x100 cleared locks the first serial region.
// - Bit 1 of byte 0x100 cleared locks the second serial region.
// - Bits 2 to 7 of byte 0x100 are not programmable, ignored.
// - Byte 0x214 bits 0 to 7 lock regions 17 to 24.
// - Bit 7 of byte 0x215 is not programmable, ignored.
// - After power-up: standby, not deep power-down, write enable clear.
// - Supply below minimum: every command ignored.
// - Delivered main array reads FFh everywhere.
// - Delivered status and configuration registers read 00h.
// - After high voltage change, commands wait the settle time; a command taken in the cycle the synchronised change appears is not held.
// - At high voltage only read status and page program accepted.
// - Quad mode makes the device ignore the acceleration pin.
`timescale 1ns/100ps
module olcg_top #(
  parameter int POWER_UP_CYC = olcg_pkg::POWER_UP_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Serial link
  input  wire logic        spi_sck_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_mosi_i,
  // Supply and acceleration pin levels
  input  wire logic        vcc_ok_i,
  input  wire logic        accel_high_voltage_i
);

  // ==========================================================
  // Declarations
  logic [olcg_pkg::FRAME_W-1:0]  frame_w;
  logic                          frame_tgl_w;
  logic [2:0]                    sync1_q;
  logic [2:0]                    sync2_q;
  logic                          tgl_seen_q;
  logic                          vcc_s;
  logic                          accel_s;
  logic                          cmd_take;
  logic [7:0]                    opc;
  logic [15:0]                   addr;
  logic [7:0]                    data;
  logic                          accel_eff;
  logic                          accel_prev_q;
  logic [olcg_pkg::SETTLE_W-1:0] settle_cnt_q;
  logic [olcg_pkg::PU_W-1:0]     pu_cnt_q;
  olcg_pkg::olcg_pwr_e           pwr_q;
  logic                          gate_ok;
  logic                          cmd_ok;
  logic                          prog_otp;
  logic                          prog_page;
  logic                          locked;
  logic [7:0]                    lock_esn_q;
  logic [7:0]                    lock_lo_q;
  logic [7:0]                    lock_hi_q;
  logic                          wel_q;
  logic                          blocked_q;
  logic [7:0]                    cfg_q;
  logic [7:0]                    read_data_q;
  logic [15:0]                   take_cnt_q;
  logic [15:0]                   ign_cnt_q;
  logic [31:0]                   rd_mux;
  logic                          bus_req;

  // ==========================================================
  // Link receiver on the serial clock
  olcg_link_rx u_link_rx (
    .spi_sck_i   (spi_sck_i),
    .spi_cs_n_i  (spi_cs_n_i),
    .spi_mosi_i  (spi_mosi_i),
    .rst_n_i     (rst_n_i),
    .frame_o     (frame_w),
    .frame_tgl_o (frame_tgl_w)
  );

  // Two-stage synchronisers for pins and the frame toggle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {frame_tgl_w, accel_high_voltage_i, vcc_ok_i};
      sync2_q <= sync1_q;
    end
  end

  // Remember last toggle seen to detect a new frame
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_seen_q <= sync2_q[2];
    end
  end

  // Frame is held stable by the link side once its toggle flips
  assign vcc_s    = sync2_q[0];
  assign accel_s  = sync2_q[1];
  assign cmd_take = sync2_q[2] ^ tgl_seen_q;
  assign opc      = frame_w[olcg_pkg::OPC_LSB +: 8];
  assign addr     = frame_w[olcg_pkg::ADDR_LSB +: 16];
  assign data     = frame_w[7:0];

  // ==========================================================
  // Acceleration pin gating
  // quad ignores pin
  assign accel_eff = accel_s & ~cfg_q[olcg_pkg::CFG_QUAD_BIT];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      accel_prev_q <= 1'b0;
      settle_cnt_q <= '0;
    end else begin
      accel_prev_q <= accel_eff;
      if (accel_eff != accel_prev_q) begin
        settle_cnt_q <= olcg_pkg::SETTLE_W'(olcg_pkg::ACCEL_SETTLE_CYC);
      end else if (settle_cnt_q != '0) begin
        settle_cnt_q <= settle_cnt_q - 1'b1;
      end
    end
  end

  // ==========================================================
  // Power state: hold after supply good, then standby
  // standby after power-up
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_q    <= olcg_pkg::PWR_WAIT;
      pu_cnt_q <= olcg_pkg::PU_W'(POWER_UP_CYC);
    end else if (!vcc_s) begin
      pwr_q    <= olcg_pkg::PWR_WAIT;
      pu_cnt_q <= olcg_pkg::PU_W'(POWER_UP_CYC);
    end else begin
      case (pwr_q)
        olcg_pkg::PWR_WAIT: begin
          if (pu_cnt_q == '0) begin
            pwr_q <= olcg_pkg::PWR_STANDBY;
          end else begin
            pu_cnt_q <= pu_cnt_q - 1'b1;
          end
        end
        olcg_pkg::PWR_STANDBY: begin
          if (cmd_ok && opc == olcg_pkg::OP_DEEP_PD) begin
            pwr_q <= olcg_pkg::PWR_DEEP;
          end
        end
        olcg_pkg::PWR_DEEP: begin
          if (cmd_ok && opc == olcg_pkg::OP_RELEASE_PD) begin
            pwr_q <= olcg_pkg::PWR_STANDBY;
          end
        end
        default: pwr_q <= olcg_pkg::PWR_WAIT;
      endcase
    end
  end

  // ==========================================================
  // Command acceptance
  // gate commands
  always_comb begin
    gate_ok = vcc_s && (pwr_q != olcg_pkg::PWR_WAIT) &&
              (settle_cnt_q == '0);
    if (accel_eff && opc != olcg_pkg::OP_READ_STATUS &&
        opc != olcg_pkg::OP_PAGE_PROGRAM) begin
      gate_ok = 1'b0;
    end
    if (pwr_q == olcg_pkg::PWR_DEEP && opc != olcg_pkg::OP_RELEASE_PD) begin
      gate_ok = 1'b0;
    end
  end

  assign cmd_ok    = cmd_take & gate_ok;
  assign prog_otp  = cmd_ok && opc == olcg_pkg::OP_OTP_PROGRAM && wel_q;
  assign prog_page = cmd_ok && opc == olcg_pkg::OP_PAGE_PROGRAM && wel_q;
  assign locked    = olcg_pkg::region_locked(addr, lock_esn_q,
                                             lock_lo_q, lock_hi_q);

  // ==========================================================
  // Lock bytes, programmed by AND so bits only fall
  // one-way lock bits
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_esn_q <= olcg_pkg::LOCK_RESET;
      lock_lo_q  <= olcg_pkg::LOCK_RESET;
      lock_hi_q  <= olcg_pkg::LOCK_RESET;
    end else if (prog_otp) begin
      if (addr == olcg_pkg::LOCK_ESN_ADDR) begin
        lock_esn_q <= lock_esn_q & (data | ~olcg_pkg::ESN_PROG_MASK);
      end
      if (addr == olcg_pkg::LOCK_OTP_LO) begin
        lock_lo_q <= lock_lo_q & (data | ~olcg_pkg::OTP_LO_MASK);
      end
      if (addr == olcg_pkg::LOCK_OTP_HI) begin
        lock_hi_q <= lock_hi_q & (data | ~olcg_pkg::OTP_HI_MASK);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blocked_q <= 1'b0;
    end else if (cmd_ok && (opc == olcg_pkg::OP_OTP_PROGRAM ||
                            opc == olcg_pkg::OP_PAGE_PROGRAM)) begin
      blocked_q <= !wel_q || (opc == olcg_pkg::OP_OTP_PROGRAM && locked);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wel_q <= 1'b0;
    end else if (!vcc_s || prog_otp || prog_page) begin
      wel_q <= 1'b0;
    end else if (cmd_ok && opc == olcg_pkg::OP_WRITE_ENABLE) begin
      wel_q <= 1'b1;
    end else if (cmd_ok && opc == olcg_pkg::OP_WRITE_DISABLE) begin
      wel_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      read_data_q <= olcg_pkg::ERASED_BYTE;
    end else if (cmd_ok && opc == olcg_pkg::OP_READ) begin
      read_data_q <= olcg_pkg::ERASED_BYTE;
    end
  end

  // Accepted and ignored command counters
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      take_cnt_q <= 16'h0000;
      ign_cnt_q  <= 16'h0000;
    end else if (cmd_take) begin
      if (gate_ok) begin
        take_cnt_q <= take_cnt_q + 1'b1;
      end else begin
        ign_cnt_q <= ign_cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // Avalon-MM slave: one wait cycle, then answer
  assign bus_req = avs_read_i | avs_write_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= olcg_pkg::CONFIG_RESET;
    end else if (avs_write_i && !avs_waitrequest_o &&
                 avs_address_i == olcg_pkg::REG_CTRL &&
                 avs_byteenable_i[0]) begin
      cfg_q <= avs_writedata_i[7:0];
    end
  end

  // Read data selection, unmapped reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      olcg_pkg::REG_CTRL:   rd_mux[7:0] = cfg_q;
      olcg_pkg::REG_STATE: begin
        rd_mux[olcg_pkg::ST_READY]    = (pwr_q != olcg_pkg::PWR_WAIT);
        rd_mux[olcg_pkg::ST_WREN]     = wel_q;
        rd_mux[olcg_pkg::ST_DEEP]     = (pwr_q == olcg_pkg::PWR_DEEP);
        rd_mux[olcg_pkg::ST_ACCEL]    = accel_eff;
        rd_mux[olcg_pkg::ST_SETTLING] = (settle_cnt_q != '0);
        rd_mux[olcg_pkg::ST_BLOCKED]  = blocked_q;
        rd_mux[olcg_pkg::ST_VCC_OK]   = vcc_s;
      end
      olcg_pkg::REG_LOCKS:  rd_mux[23:0] = {lock_hi_q, lock_lo_q, lock_esn_q};
      olcg_pkg::REG_COUNTS: rd_mux = {ign_cnt_q, take_cnt_q};
      olcg_pkg::REG_FLASH: begin
        rd_mux[7:0] = olcg_pkg::STATUS_RESET;
        rd_mux[olcg_pkg::STS_WREN_BIT] = wel_q;
        rd_mux[15:8]  = cfg_q;
        rd_mux[23:16] = read_data_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data registered in the wait cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Helper for locked check on a fixed address
  function automatic logic locked_at(input logic [15:0] a);
    locked_at = olcg_pkg::region_locked(a, lock_esn_q, lock_lo_q, lock_hi_q);
  endfunction

  AST_LOCK_ONE_WAY: assert property (
    ({lock_esn_q, lock_lo_q, lock_hi_q} &
     ~$past({lock_esn_q, lock_lo_q, lock_hi_q})) == 24'h000000)
    else $error("lock bit returned to one");
  AST_ESN_LOCK: assert property (
    prog_otp && addr == olcg_pkg::LOCK_ESN_ADDR && !data[0] |=>
    !lock_esn_q[0] && locked_at(olcg_pkg::SER1_FIRST))
    else $error("first serial region not locked");
  AST_ESN_RESERVED: assert property (
    lock_esn_q[7:2] == 6'h3F && lock_hi_q[7])
    else $error("reserved lock bit changed");
  AST_LOW_SUPPLY: assert property (
    !vcc_s |-> !cmd_ok ##1 !cmd_ok)
    else $error("command accepted at low supply");
  AST_ACCEL_ONLY: assert property (
    cmd_ok && accel_eff |-> opc == olcg_pkg::OP_READ_STATUS ||
                            opc == olcg_pkg::OP_PAGE_PROGRAM)
    else $error("forbidden command at high voltage");
  AST_SETTLE: assert property (
    $changed(accel_eff) |=> !cmd_ok [*8])
    else $error("command during settle time");
  AST_QUAD_IGNORE: assert property (
    cfg_q[olcg_pkg::CFG_QUAD_BIT] |-> !accel_eff)
    else $error("pin active in quad mode");
  AST_LOCKED_KEEP: assert property (
    prog_otp && locked |=> $stable({lock_esn_q, lock_lo_q, lock_hi_q}) &&
                           blocked_q)
    else $error("locked region program had effect");
  AST_HOLD_CLEAN: assert property (
    pwr_q == olcg_pkg::PWR_WAIT |-> !wel_q ##1 pwr_q != olcg_pkg::PWR_DEEP)
    else $error("power-up state not clean");

  COV_LOCK_PROG: cover property (prog_otp && !locked);
  COV_ACCEL_CMD: cover property (cmd_ok && accel_eff);
  COV_SETTLE_IGN: cover property (cmd_take && settle_cnt_q != '0);
  COV_DEEP: cover property (pwr_q == olcg_pkg::PWR_DEEP);

endmodule // olcg_top

/* bench/olcg_host_model.sv */
/*
  Host side of the serial link: sends 32-bit frames MSB first.
  Assumes the bench spaces frames and holds off commands as needed.
*/
`timescale 1ns/100ps
module olcg_host_model (
  // Link
  output logic spi_sck_o,
  output logic spi_cs_n_o,
  output logic spi_mosi_o
);
  // ==========================================================
  // Idle state: clock still, select high
  initial begin
    spi_sck_o  = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end

  // Frame sender on a 125 ns clock, data set while clock low
  task automatic send(input logic [31:0] f);
    #17;
    spi_cs_n_o = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      spi_mosi_o = f[i];
      #62.5;
      spi_sck_o = 1'b1;
      #62.5;
      spi_sck_o = 1'b0;
    end
    #30;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = ~f[0];  // Released line shows no stale bit
  endtask
endmodule // olcg_host_model

/* bench/tb_top.sv */
/*
  Self-checking bench for the lock map and command gating block.
  Assumes Avalon-MM timing and register map as handed over.
*/
`timescale 1ns/100ps
`define OLCG_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_top;
  localparam int PU = 20;
  localparam logic [15:0] TGT [5] = '{16'h0102, 16'h010A, 16'h0216,
                                      16'h0286, 16'h02F6};
  logic clk_i, rst_n_i, avs_read_i, avs_write_i, vcc_ok_i, hv_i;
  logic [4:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic        avs_waitrequest_o, sck, cs_n, mosi;
  logic [7:0]  lk0, lk1, lk2, r;
  int          miscompares, checks_done, ok_n, ign_n;
  bit          wen, blk;
  // ==========================================================
  // Design and host model
  olcg_top #(.POWER_UP_CYC(PU)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .spi_sck_i(sck),
    .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .vcc_ok_i(vcc_ok_i),
    .accel_high_voltage_i(hv_i));
  olcg_host_model u_host (.spi_sck_o(sck), .spi_cs_n_o(cs_n),
    .spi_mosi_o(mosi));
  // Clock, 50 ns
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Pseudo-random byte source
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // One Avalon transfer, bounded wait for waitrequest low
  task automatic bus(input bit w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 40) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // Whether an address sits in a locked region
  function automatic bit lkd(input logic [15:0] a);
    int k;
    if (a >= 16'h0102 && a <= 16'h0109) return ~lk0[0];
    if (a >= 16'h010A && a <= 16'h0111) return ~lk0[1];
    if (a < 16'h0216 || a > 16'h02FF) return 1'b0;
    k = (a - 16'h0216) >> 4;
    return (k < 8) ? ~lk1[k] : ~lk2[k-8];
  endfunction
  // Send a frame, update the model, compare counts and state
  task automatic frm(input logic [7:0] op, input logic [15:0] a,
                     input logic [7:0] d, input bit ok);
    @(posedge clk_i);
    u_host.send({op, a, d});
    repeat (12) @(posedge clk_i);
    if (!ok) ign_n++;
    else begin
      ok_n++;
      if (op == 8'h06) wen = 1'b1;
      if (op == 8'h04) wen = 1'b0;
      if (op == 8'h42 && wen) begin
        blk = lkd(a);
        wen = 1'b0;
        if (a == 16'h0100) lk0 &= d | 8'hFC;
        if (a == 16'h0214) lk1 &= d;
        if (a == 16'h0215) lk2 &= d | 8'h80;
      end
    end
    bus(1'b0, 5'h0C, 32'h0);
    `OLCG_CHK(q, {ign_n[15:0], ok_n[15:0]})
    bus(1'b0, 5'h08, 32'h0);
    `OLCG_CHK(q[23:0], {lk2, lk1, lk0})
    bus(1'b0, 5'h04, 32'h0);
    `OLCG_CHK(q[1], wen)
    if (op == 8'h42 && ok) `OLCG_CHK(q[5], blk)
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {avs_read_i, avs_write_i, vcc_ok_i, hv_i, rst_n_i} = 5'h00;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0;
    {lk0, lk1, lk2, r} = 32'hFFFFFF33;
    {miscompares, checks_done, ok_n, ign_n, wen, blk} = '0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    bus(1'b0, 5'h10, 32'h0);
    `OLCG_CHK(q[15:0], 16'h0000)
    bus(1'b0, 5'h14, 32'h0);
    `OLCG_CHK(q, 32'h0)
    frm(8'h06, 16'h0, 8'h0, 1'b0);
    vcc_ok_i <= 1'b1;
    repeat (PU + 20) @(posedge clk_i);
    bus(1'b0, 5'h04, 32'h0);
    `OLCG_CHK(q[2:0], 3'b001)
    frm(8'h03, 16'h1234, 8'h0, 1'b1);
    bus(1'b0, 5'h10, 32'h0);
    `OLCG_CHK(q[23:16], 8'hFF)
    for (int i = 0; i < 9; i++) begin
      r = lfsr(r);
      frm(8'h06, 16'h0, 8'h0, 1'b1);
      frm(8'h42, (i % 3 == 0) ? 16'h0100 : 16'h0213 + i % 3, r, 1'b1);
    end
    for (int j = 0; j < 5; j++) begin
      frm(8'h06, 16'h0, 8'h0, 1'b1);
      frm(8'h42, TGT[j], 8'h00, 1'b1);
    end
    // Deep power-down ignores all but release
    frm(8'hB9, 16'h0, 8'h0, 1'b1);
    frm(8'h06, 16'h0, 8'h0, 1'b0);
    bus(1'b0, 5'h04, 32'h0);
    `OLCG_CHK(q[2], 1'b1)
    frm(8'hAB, 16'h0, 8'h0, 1'b1);
    hv_i <= 1'b1;
    repeat (130) @(posedge clk_i);
    frm(8'h06, 16'h0, 8'h0, 1'b0);
    frm(8'h05, 16'h0, 8'h0, 1'b1);
    hv_i <= 1'b0;
    frm(8'h05, 16'h0, 8'h0, 1'b0);
    repeat (130) @(posedge clk_i);
    bus(1'b1, 5'h00, 32'h2);
    hv_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    frm(8'h06, 16'h0, 8'h0, 1'b1);
    vcc_ok_i <= 1'b0;
    wen = 1'b0;
    frm(8'h06, 16'h0, 8'h0, 1'b0);
    tally_and_finish();
  end
endmodule // tb_top
